// ### common/atp_pkg.sv
// constants and carrier types of the autoreload timer with pwm channel
package atp_pkg;
    localparam int          CNT_W         = 12;
    localparam int          PSC_W         = 5;
    localparam logic [11:0] CNT_MAX       = 12'hFFF;
    localparam logic [11:0] CNT_RST       = 12'h000;
    localparam logic [4:0]  SLOW_LAST     = 5'h1F;
    localparam logic [7:0]  BYTE_RST      = 8'h00;
    // register indices, byte address is four times the index
    localparam logic [5:0]  IDX_TCS       = 6'h0D;
    localparam logic [5:0]  IDX_CNTH      = 6'h0E;
    localparam logic [5:0]  IDX_CNTL      = 6'h0F;
    localparam logic [5:0]  IDX_RLDH      = 6'h10;
    localparam logic [5:0]  IDX_RLDL      = 6'h11;
    localparam logic [5:0]  IDX_OCTL      = 6'h12;
    localparam logic [5:0]  IDX_CHCS      = 6'h13;
    localparam logic [5:0]  IDX_DUTH      = 6'h17;
    localparam logic [5:0]  IDX_DUTL      = 6'h18;
    localparam logic [5:0]  IDX_PWR       = 6'h19;
    // field positions
    localparam int          TCS_CKSEL_LSB = 3;
    localparam int          TCS_OVF_BIT   = 2;
    localparam int          TCS_OVERFLOW_IRQ_ENABLE_BIT = 1;
    localparam int          TCS_COMPARE_IRQ_ENABLE_BIT = 0;
    localparam int          CHCS_POL_BIT  = 1;
    localparam int          CHCS_CMPF_BIT = 0;
    localparam int          OCTL_OE_BIT   = 0;
    // counter clock selector codes
    localparam logic [1:0]  CKSEL_OFF     = 2'h0;
    localparam logic [1:0]  CKSEL_TICK    = 2'h1;
    localparam logic [1:0]  CKSEL_CPU     = 2'h2;
    // power modes
    localparam logic [2:0]  PWR_RUN       = 3'h0;
    localparam logic [2:0]  PWR_SLOW      = 3'h1;
    localparam logic [2:0]  PWR_WAIT      = 3'h2;
    localparam logic [2:0]  PWR_DIDLE     = 3'h3;
    localparam logic [2:0]  PWR_STOP      = 3'h4;
    // bus responses
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef struct packed {
        logic [1:0] clk_sel;
        logic       ovf_ie;
        logic       cmp_ie;
    } atp_tctl_type;

    typedef struct packed {
        logic oe;
        logic pol;
    } atp_chan_type;
endpackage

// ### rtl/atp_timer.sv
// 12-bit autoreload timer with one pwm / output-compare channel, axi4-lite slave
// Contract
// - counter counts up and reloads from reload value after overflow
// - step from all ones to reload value is overflow; sets overflow flag
// - overflow flag cleared by reading timer control/status; set only by hardware
// - overflow flag stays high one counter clock period
// - selector: 00 off, 01 timebase tick, 10 cpu clock, 11 reserved
// - counter resets to zero and counts whenever a clock is selected and the power mode does not halt it
// - pwm period is 4096 minus reload value counter clocks
// - output enable drives pwm pin; clear leaves pin to general use
// - at overflow: reload, copy duty to shadow, set output high
// - counter equal to active duty drives output low
// - polarity bit inverts output
// - duty high write suspends compare until duty low write
// - output-compare mode uses written duty immediately
// - match sets compare flag; interrupt if compare enable set
// - compare value zero gives no compare events
// - shadow copied at overflow even with low byte unwritten
// - pwm mode compares shadow; compare mode compares duty register
// - reduced-clock mode divides counter input by 32; core idle no effect
// - deep idle halts unless tick selected and overflow irq enabled; stop halts
// - separate irqs; wake rules per power mode
// - compare flag set on match, cleared by reading channel status
// - polarity bit zero non-inverted, one inverted, cleared at reset
`timescale 1ns/1ps
module atp_timer #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              CLK_SYS_IN,
    input  wire logic              RST_N_IN,
    // axi4-lite write channels
    input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_IN,
    input  wire logic              S_AXI_AWVALID_IN,
    output logic                   S_AXI_AWREADY_OUT,
    input  wire logic [31:0]       S_AXI_WDATA_IN,
    input  wire logic [3:0]        S_AXI_WSTRB_IN,
    input  wire logic              S_AXI_WVALID_IN,
    output logic                   S_AXI_WREADY_OUT,
    output logic [1:0]             S_AXI_BRESP_OUT,
    output logic                   S_AXI_BVALID_OUT,
    input  wire logic              S_AXI_BREADY_IN,
    // axi4-lite read channels
    input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_IN,
    input  wire logic              S_AXI_ARVALID_IN,
    output logic                   S_AXI_ARREADY_OUT,
    output logic [31:0]            S_AXI_RDATA_OUT,
    output logic [1:0]             S_AXI_RRESP_OUT,
    output logic                   S_AXI_RVALID_OUT,
    input  wire logic              S_AXI_RREADY_IN,
    // timebase tick from the neighbouring timer
    input  wire logic              TIMEBASE_TICK_IN,
    // pwm pin and interrupts
    output logic                   MODULATED_OUTPUT_OUT,
    output logic                   PWM_OUT_ENABLE_OUT,
    output logic                   OVF_IRQ_OUT,
    output logic                   CMP_IRQ_OUT
);
    import atp_pkg::*;
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RST_N_IN);
    function automatic logic [5:0] reg_idx(input logic [ADDR_W-1:0] a);
        return a[7:2];
    endfunction
    function automatic logic mapped(input logic [5:0] i);
        return (i >= IDX_TCS && i <= IDX_CHCS) || (i >= IDX_DUTH && i <= IDX_PWR);
    endfunction
    atp_tctl_type     tctl_q;
    atp_chan_type     chan_q;
    logic [2:0]       pwr_q;
    logic [11:0]      cnt_q;
    logic [11:0]      reload_q;
    logic [11:0]      duty_q;
    logic [11:0]      shadow_q;
    logic [4:0]       psc_q;
    logic             lock_q;
    logic             ovf_q;
    logic             cmpf_q;
    logic             lvl_q;
    logic             pin_q;
    logic             ovf_irq_q;
    logic             cmp_irq_q;
    logic             awready_q;
    logic             wready_q;
    logic             bvalid_q;
    logic [1:0]       bresp_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [7:0]       wbyte_q;
    logic             wlane_q;
    logic             arready_q;
    logic             rvalid_q;
    logic [31:0]      rdata_q;
    logic [1:0]       rresp_q;
    // bus slave
    logic       wr_do;
    logic       rd_do;
    logic [5:0] wr_idx;
    logic [5:0] rd_idx;
    logic       wr_ok;
    assign wr_do  = !awready_q && !wready_q && !bvalid_q;
    assign rd_do  = S_AXI_ARVALID_IN && arready_q;
    assign wr_idx = reg_idx(awaddr_q);
    assign rd_idx = reg_idx(S_AXI_ARADDR_IN);
    // registers are one byte wide, only lane 0 stores
    assign wr_ok  = wr_do && wlane_q;
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            awaddr_q  <= '0;
            wbyte_q   <= BYTE_RST;
            wlane_q   <= 1'b0;
        end else begin
            if (S_AXI_AWVALID_IN && awready_q) begin
                awready_q <= 1'b0;
                awaddr_q  <= S_AXI_AWADDR_IN;
            end
            if (S_AXI_WVALID_IN && wready_q) begin
                wready_q <= 1'b0;
                wbyte_q  <= S_AXI_WDATA_IN[7:0];
                wlane_q  <= S_AXI_WSTRB_IN[0];
            end
            if (wr_do) begin
                bvalid_q <= 1'b1;
                bresp_q  <= mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_q && S_AXI_BREADY_IN) begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= RESP_OKAY;
        end else if (rd_do) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rresp_q   <= mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
            case (rd_idx)
                IDX_TCS:  rdata_q <= {24'h0000_00, 3'h0, tctl_q.clk_sel, ovf_q,
                                      tctl_q.ovf_ie, tctl_q.cmp_ie};
                IDX_CNTH: rdata_q <= {28'h000_0000, cnt_q[11:8]};
                IDX_CNTL: rdata_q <= {24'h0000_00, cnt_q[7:0]};
                IDX_RLDH: rdata_q <= {28'h000_0000, reload_q[11:8]};
                IDX_RLDL: rdata_q <= {24'h0000_00, reload_q[7:0]};
                IDX_OCTL: rdata_q <= {31'h0000_0000, chan_q.oe};
                IDX_CHCS: rdata_q <= {30'h0000_0000, chan_q.pol, cmpf_q};
                IDX_DUTH: rdata_q <= {28'h000_0000, duty_q[11:8]};
                IDX_DUTL: rdata_q <= {24'h0000_00, duty_q[7:0]};
                IDX_PWR:  rdata_q <= {29'h0000_0000, pwr_q};
                default:  rdata_q <= '0;
            endcase
        end else if (rvalid_q && S_AXI_RREADY_IN) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end
    end
    // software registers
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            tctl_q   <= '0;
            chan_q   <= '0;
            pwr_q    <= PWR_RUN;
            reload_q <= CNT_RST;
            duty_q   <= CNT_RST;
        end else if (wr_ok) begin
            case (wr_idx)
                IDX_TCS: begin
                    tctl_q.clk_sel <= wbyte_q[TCS_CKSEL_LSB +: 2];
                    tctl_q.ovf_ie  <= wbyte_q[TCS_OVERFLOW_IRQ_ENABLE_BIT];
                    tctl_q.cmp_ie  <= wbyte_q[TCS_COMPARE_IRQ_ENABLE_BIT];
                end
                IDX_RLDH: reload_q[11:8] <= wbyte_q[3:0];
                IDX_RLDL: reload_q[7:0]  <= wbyte_q;
                IDX_OCTL: chan_q.oe      <= wbyte_q[OCTL_OE_BIT];
                IDX_CHCS: chan_q.pol     <= wbyte_q[CHCS_POL_BIT];
                IDX_DUTH: duty_q[11:8]   <= wbyte_q[3:0];
                IDX_DUTL: duty_q[7:0]    <= wbyte_q;
                IDX_PWR:  pwr_q          <= wbyte_q[2:0];
                default: ;
            endcase
        end
    end
    // high byte write holds off compare until the low byte lands
    logic duth_wr;
    logic dutl_wr;
    assign duth_wr = wr_ok && wr_idx == IDX_DUTH;
    assign dutl_wr = wr_ok && wr_idx == IDX_DUTL;
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN)
            lock_q <= 1'b0;
        else if (duth_wr)
            lock_q <= 1'b1;
        else if (dutl_wr)
            lock_q <= 1'b0;
    end
    sequence s_duth_wr;
        duth_wr;
    endsequence
    sequence s_locked_till_low;
        lock_q throughout (!dutl_wr [*1]);
    endsequence
    property p_lock;
        s_duth_wr |=> s_locked_till_low;
    endproperty
    a_lock: assert property (p_lock) else $error("duty high write did not lock compare");
    // counter clock
    logic base_tick;
    logic run_en;
    logic cnt_tick;
    // reserved selector falls to default and stays stopped
    always_comb begin
        case (tctl_q.clk_sel)
            CKSEL_TICK: base_tick = TIMEBASE_TICK_IN;
            CKSEL_CPU:  base_tick = 1'b1;
            default:    base_tick = 1'b0;
        endcase
    end
    assign run_en = pwr_q != PWR_STOP &&
                    !(pwr_q == PWR_DIDLE &&
                      !(tctl_q.clk_sel == CKSEL_TICK && tctl_q.ovf_ie));
    // core-idle mode leaves the count untouched, reduced clock divides by 32
    assign cnt_tick = base_tick && run_en &&
                      (pwr_q != PWR_SLOW || psc_q == SLOW_LAST);
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN)
            psc_q <= '0;
        else if (base_tick && run_en)
            psc_q <= psc_q + 5'h01;
    end
    // a stuck prescaler would let ticks follow back to back
    property p_slow_div;
        (pwr_q == PWR_SLOW && cnt_tick) ##1 (pwr_q == PWR_SLOW) |-> !cnt_tick;
    endproperty
    a_slow_div: assert property (p_slow_div) else $error("slow mode tick not divided");
    property p_off;
        (tctl_q.clk_sel == CKSEL_OFF || tctl_q.clk_sel == 2'h3 || pwr_q == PWR_STOP)
            |-> !cnt_tick;
    endproperty
    a_off: assert property (p_off) else $error("counter ticked while stopped");
    // counter and overflow
    logic [11:0] cnt_nxt;
    logic        ovf_evt;
    assign ovf_evt = cnt_tick && cnt_q == CNT_MAX;
    assign cnt_nxt = (cnt_q == CNT_MAX) ? reload_q : cnt_q + 12'h001;
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN)
            cnt_q <= CNT_RST;
        else if (cnt_tick)
            cnt_q <= cnt_nxt;
    end
    property p_reload; ovf_evt |=> cnt_q == $past(reload_q); endproperty
    a_reload: assert property (p_reload) else $error("counter did not reload");
    // set wins over a same-cycle read or period end
    logic tcs_rd;
    assign tcs_rd = rd_do && rd_idx == IDX_TCS;
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN)
            ovf_q <= 1'b0;
        else if (ovf_evt)
            ovf_q <= 1'b1;
        else if (tcs_rd || cnt_tick)
            ovf_q <= 1'b0;
    end
    property p_ovf_clear;
        (ovf_q && !ovf_evt && (tcs_rd || cnt_tick)) |=> !ovf_q;
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("overflow flag not cleared");
    property p_ovf_hold;
        (ovf_evt ##1 (!tcs_rd && !cnt_tick) [*2]) |-> ovf_q;
    endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag dropped early");
    // compare
    logic [11:0] cmp_val;
    logic        cmp_on;
    logic        match_evt;
    assign cmp_val   = chan_q.oe ? shadow_q : duty_q;
    assign cmp_on    = !lock_q && cmp_val != CNT_RST;
    assign match_evt = cnt_tick && cmp_on && cnt_nxt == cmp_val;
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN)
            shadow_q <= CNT_RST;
        else if (ovf_evt)
            shadow_q <= duty_q;
    end
    property p_shadow; ovf_evt |=> shadow_q == $past(duty_q); endproperty
    a_shadow: assert property (p_shadow) else $error("shadow not loaded at overflow");
    property p_no_cmp; (lock_q || cmp_val == CNT_RST) |-> !match_evt; endproperty
    a_no_cmp: assert property (p_no_cmp) else $error("compare fired while inhibited");
    logic chcs_rd;
    assign chcs_rd = rd_do && rd_idx == IDX_CHCS;
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN)
            cmpf_q <= 1'b0;
        else if (match_evt)
            cmpf_q <= 1'b1;
        else if (chcs_rd)
            cmpf_q <= 1'b0;
    end
    property p_cmpf; match_evt |=> cmpf_q; endproperty
    a_cmpf: assert property (p_cmpf) else $error("compare flag not set on match");
    // pwm level and pin
    // match after overflow wins, so duty equal to reload keeps the level low
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN)
            lvl_q <= 1'b0;
        else if (match_evt)
            lvl_q <= 1'b0;
        else if (ovf_evt)
            lvl_q <= 1'b1;
    end
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN)
            pin_q <= 1'b0;
        else
            pin_q <= chan_q.oe && (lvl_q ^ chan_q.pol);
    end
    sequence s_pwm_match;
        chan_q.oe && match_evt;
    endsequence
    // pin copies enable and polarity one edge late, so compare against those
    property p_pwm_low;
        s_pwm_match ##1 chan_q.oe |=> MODULATED_OUTPUT_OUT == $past(chan_q.pol);
    endproperty
    a_pwm_low: assert property (p_pwm_low) else $error("pwm level not low after match");
    // interrupt requests
    logic ovf_wake_ok;
    logic cmp_wake_ok;
    assign ovf_wake_ok = pwr_q != PWR_STOP &&
                         (pwr_q != PWR_DIDLE || tctl_q.clk_sel == CKSEL_TICK);
    assign cmp_wake_ok = pwr_q != PWR_STOP && pwr_q != PWR_DIDLE;
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            ovf_irq_q <= 1'b0;
            cmp_irq_q <= 1'b0;
        end else begin
            ovf_irq_q <= ovf_q && tctl_q.ovf_ie && ovf_wake_ok;
            cmp_irq_q <= cmpf_q && tctl_q.cmp_ie && cmp_wake_ok;
        end
    end
    property p_cmp_irq;
        (cmpf_q && tctl_q.cmp_ie && pwr_q == PWR_RUN) |=> CMP_IRQ_OUT;
    endproperty
    a_cmp_irq: assert property (p_cmp_irq) else $error("compare irq not raised");
    // outputs
    assign S_AXI_AWREADY_OUT    = awready_q;
    assign S_AXI_WREADY_OUT     = wready_q;
    assign S_AXI_BVALID_OUT     = bvalid_q;
    assign S_AXI_BRESP_OUT      = bresp_q;
    assign S_AXI_ARREADY_OUT    = arready_q;
    assign S_AXI_RVALID_OUT     = rvalid_q;
    assign S_AXI_RDATA_OUT      = rdata_q;
    assign S_AXI_RRESP_OUT      = rresp_q;
    assign MODULATED_OUTPUT_OUT = pin_q;
    assign PWM_OUT_ENABLE_OUT   = chan_q.oe;
    assign OVF_IRQ_OUT          = ovf_irq_q;
    assign CMP_IRQ_OUT          = cmp_irq_q;
endmodule // atp_timer

// ### bench/tb_top.sv
// self-checking bench of the autoreload timer, driven over axi4-lite
`timescale 1ns/1ps
module tb_top;
    import atp_pkg::*;
    logic        clk     = 1'b0;
    logic        rst_n   = 1'b0;
    logic [7:0]  awaddr  = 8'h00;
    logic        awvalid = 1'b0;
    logic [31:0] wdata   = 32'h0000_0000;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b0;
    logic [7:0]  araddr  = 8'h00;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b0;
    logic        tick    = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, bresp_c, rresp_c;
    logic [31:0] rdata, rdata_c;
    logic        aw_hs, w_hs, b_hs, ar_hs, r_hs;
    logic        pin, pin_en, ovf_irq, cmp_irq;
    logic        win = 1'b0;
    int          num_errors = 0;
    int          tests_run = 0;
    int          pwm_c, ovf_c;
    logic [5:0]  regs [10] = '{IDX_TCS, IDX_CNTH, IDX_CNTL, IDX_RLDH, IDX_RLDL,
                               IDX_OCTL, IDX_CHCS, IDX_DUTH, IDX_DUTL, IDX_PWR};

    always #4 clk = ~clk;

    atp_timer atp_timer_i (
        .CLK_SYS_IN(clk), .RST_N_IN(rst_n),
        .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
        .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'h1), .S_AXI_WVALID_IN(wvalid),
        .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
        .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
        .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
        .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready), .TIMEBASE_TICK_IN(tick),
        .MODULATED_OUTPUT_OUT(pin), .PWM_OUT_ENABLE_OUT(pin_en),
        .OVF_IRQ_OUT(ovf_irq), .CMP_IRQ_OUT(cmp_irq)
    );

    // handshakes captured with pre-edge values, so tasks never race the slave's flops
    always @(posedge clk) begin
        aw_hs   <= awvalid & awready;
        w_hs    <= wvalid & wready;
        b_hs    <= bvalid & bready;
        bresp_c <= bresp;
        ar_hs   <= arvalid & arready;
        r_hs    <= rvalid & rready;
        rdata_c <= rdata;
        rresp_c <= rresp;
    end

    // sampled mid-cycle where pin and irqs have settled
    always @(negedge clk) begin
        if (win) begin
            pwm_c += int'(pin === 1'b1);
            ovf_c += int'(ovf_irq === 1'b1);
        end
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [5:0] i, input logic [7:0] d, input logic [1:0] er);
        int   n;
        logic pa, pw, pb;
        n  = 0;
        pa = 1'b1;
        pw = 1'b1;
        pb = 1'b1;
        // idle edge first, so a ready released by the last call is not raised in one step
        wt(1);
        awaddr  <= {i, 2'b00};
        wdata   <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while ((pa | pw | pb) && n < 50) begin
            wt(1);
            n++;
            if (aw_hs) begin
                pa = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_hs) begin
                pw = 1'b0;
                wvalid <= 1'b0;
            end
            if (b_hs) begin
                pb = 1'b0;
                bready <= 1'b0;
                chk("bresp", {30'h0000_0000, er}, {30'h0000_0000, bresp_c});
            end
        end
        if (pb) chk("write_done", 32'h0000_0001, 32'h0000_0000);
    endtask

    task automatic rd(input logic [5:0] i, input logic [7:0] ed, input logic [1:0] er);
        int   n;
        logic pr;
        n  = 0;
        pr = 1'b1;
        wt(1);
        araddr  <= {i, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (pr && n < 50) begin
            wt(1);
            n++;
            if (ar_hs) arvalid <= 1'b0;
            if (r_hs) begin
                pr = 1'b0;
                rready <= 1'b0;
                chk("rdata", {24'h00_0000, ed}, rdata_c);
                chk("rresp", {30'h0000_0000, er}, {30'h0000_0000, rresp_c});
            end
        end
        if (pr) chk("read_done", 32'h0000_0001, 32'h0000_0000);
    endtask

    task automatic pulse(input int n);
        repeat (n) begin
            tick <= 1'b1;
            wt(1);
            tick <= 1'b0;
            wt(1);
        end
    endtask

    task automatic window;
        pwm_c = 0;
        ovf_c = 0;
        win = 1'b1;
        wt(60);
        win = 1'b0;
    endtask

    initial begin
        wt(20000);
        num_errors++;
        wrap_up();
    end

    initial begin
        wt(4);
        rst_n <= 1'b1;
        wt(1);
        // reset values and unmapped place
        foreach (regs[k]) rd(regs[k], 8'h00, RESP_OKAY);
        rd(6'h00, 8'h00, RESP_SLVERR);
        wr(6'h00, 8'h5A, RESP_SLVERR);
        chk("pwm_enable", 32'h0000_0000, {31'h0000_0000, pin_en});
        $display("test reset done");
        // output compare on the tick clock, lock by the high byte
        wr(IDX_TCS, 8'h09, RESP_OKAY);
        wr(IDX_DUTH, 8'h00, RESP_OKAY);
        wr(IDX_DUTL, 8'h03, RESP_OKAY);
        wr(IDX_DUTH, 8'h00, RESP_OKAY);
        pulse(4);
        rd(IDX_CNTL, 8'h04, RESP_OKAY);
        rd(IDX_CHCS, 8'h00, RESP_OKAY);
        wr(IDX_DUTL, 8'h06, RESP_OKAY);
        pulse(2);
        wt(2);
        chk("cmp_irq", 32'h0000_0001, {31'h0000_0000, cmp_irq});
        rd(IDX_CHCS, 8'h01, RESP_OKAY);
        rd(IDX_CHCS, 8'h00, RESP_OKAY);
        wt(2);
        chk("cmp_irq_low", 32'h0000_0000, {31'h0000_0000, cmp_irq});
        $display("test compare done");
        // power modes, counter now at 6
        wr(IDX_PWR, {5'h00, PWR_SLOW}, RESP_OKAY);
        pulse(32);
        rd(IDX_CNTL, 8'h07, RESP_OKAY);
        wr(IDX_PWR, {5'h00, PWR_STOP}, RESP_OKAY);
        pulse(3);
        rd(IDX_CNTL, 8'h07, RESP_OKAY);
        wr(IDX_PWR, {5'h00, PWR_DIDLE}, RESP_OKAY);
        pulse(3);
        rd(IDX_CNTL, 8'h07, RESP_OKAY);
        wr(IDX_TCS, 8'h0B, RESP_OKAY);
        pulse(3);
        rd(IDX_CNTL, 8'h0A, RESP_OKAY);
        wr(IDX_PWR, {5'h00, PWR_WAIT}, RESP_OKAY);
        pulse(2);
        rd(IDX_CNTL, 8'h0C, RESP_OKAY);
        wr(IDX_PWR, {5'h00, PWR_RUN}, RESP_OKAY);
        $display("test power done");
        // off and reserved selector codes hold the counter
        wr(IDX_TCS, 8'h00, RESP_OKAY);
        pulse(2);
        rd(IDX_CNTL, 8'h0C, RESP_OKAY);
        wr(IDX_TCS, 8'h18, RESP_OKAY);
        pulse(2);
        wt(20);
        rd(IDX_CNTL, 8'h0C, RESP_OKAY);
        rd(IDX_CNTH, 8'h00, RESP_OKAY);
        $display("test selector done");
        // pwm: reload FFA gives period 6, duty FFC gives 2 high
        wr(IDX_RLDH, 8'h0F, RESP_OKAY);
        wr(IDX_RLDL, 8'hFA, RESP_OKAY);
        rd(IDX_RLDH, 8'h0F, RESP_OKAY);
        rd(IDX_RLDL, 8'hFA, RESP_OKAY);
        wr(IDX_DUTH, 8'h0F, RESP_OKAY);
        wr(IDX_DUTL, 8'hFC, RESP_OKAY);
        wr(IDX_OCTL, 8'h01, RESP_OKAY);
        chk("pwm_enable", 32'h0000_0001, {31'h0000_0000, pin_en});
        wr(IDX_TCS, 8'h12, RESP_OKAY);
        wt(4200);
        window();
        chk("pwm_high", 32'd20, pwm_c);
        chk("ovf_irq_count", 32'd10, ovf_c);
        wr(IDX_CHCS, 8'h02, RESP_OKAY);
        wt(10);
        window();
        chk("pwm_high_inv", 32'd40, pwm_c);
        rd(IDX_CHCS, 8'h03, RESP_OKAY);
        $display("test pwm done");
        // back to output compare with a zero value
        wr(IDX_OCTL, 8'h00, RESP_OKAY);
        wt(3);
        chk("pwm_enable", 32'h0000_0000, {31'h0000_0000, pin_en});
        chk("pwm_pin", 32'h0000_0000, {31'h0000_0000, pin});
        wr(IDX_RLDH, 8'h00, RESP_OKAY);
        wr(IDX_RLDL, 8'h00, RESP_OKAY);
        wr(IDX_DUTH, 8'h00, RESP_OKAY);
        rd(IDX_CHCS, 8'h03, RESP_OKAY);
        wr(IDX_DUTL, 8'h00, RESP_OKAY);
        wt(4200);
        rd(IDX_CHCS, 8'h02, RESP_OKAY);
        $display("test zero compare done");
        wrap_up();
    end
endmodule // tb_top
